// *** hdl/oam_pkg.sv ***
package oam_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_STATUS_LOW  = 8'h50;
	localparam logic [7:0] IDX_STATUS_HIGH = 8'h51;
	localparam logic [7:0] IDX_VENDOR0     = 8'h52;
	localparam logic [7:0] IDX_VENDOR1     = 8'h53;
	localparam logic [7:0] IDX_VENDOR2     = 8'h54;
	localparam logic [7:0] IDX_IRQ_STATUS  = 8'h60;
	localparam logic [7:0] IDX_IRQ_MASK    = 8'h61;
	localparam logic [7:0] IDX_ROLE_CTRL   = 8'h62;

	// Status low fields
	localparam int BIT_ROLE      = 6;
	localparam int BIT_LOOPBACK  = 5;
	localparam int BIT_NOTIFY    = 4;
	localparam int BIT_DIAG      = 3;
	localparam int BIT_LINKDOWN  = 2;
	localparam int BIT_OPTDETECT = 1;
	localparam int BIT_PWRDOWN   = 0;
	// Status high fields
	localparam int BIT_IFCOUNT   = 3;
	localparam int BIT_ANEG      = 2;
	localparam int BIT_DUPLEX    = 1;
	localparam int BIT_SPEED     = 0;
	// Port control register bit mirrored as autoneg capability
	localparam int PORTCTL_ANEG_BIT = 5;

	// Reset values
	localparam logic       RST_NOTIFY   = 1'b0;
	localparam logic       RST_LINKDOWN = 1'b1;
	localparam logic       RST_IFCOUNT  = 1'b0;
	localparam logic [7:0] RST_VENDOR   = 8'h00;
	localparam logic [4:0] RST_IRQ_MASK = 5'h00;

	// Interrupt status bits: changes of watched state
	localparam int IRQ_LINK     = 0;
	localparam int IRQ_OPT      = 1;
	localparam int IRQ_DIAG     = 2;
	localparam int IRQ_PWR      = 3;
	localparam int IRQ_LOOPBACK = 4;
	localparam int IRQ_W        = 5;
endpackage

// *** hdl/oam_local_status_regs.sv ***
`timescale 1ns/1ns
// Behaviour
// - Role bit 6: 1 terminal, 0 center
// - Loopback bit 5 set while looping back
// - Notify bit 4: 1 far-end fault, 0 frames
// - Terminal mode: notify bit follows strap input
// - Terminal mode: diag bit follows fail pin
// - Linkdown bit 2 resets 1, hardware in terminal
// - Bit 1 mirrors optical detect pin
// - Bit 0 is inverse of power-down pin
// - Autoneg bit mirrors port control bit, terminal
// - Duplex bit: full and link up, terminal
// - Speed bit: 100M and link up, terminal
module oam_local_status_regs
	import oam_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Device pins and port status
	input  wire logic        terminalMode,
	input  wire logic        loopbackActive,
	input  wire logic        notifyStrap,
	input  wire logic        diagnostic_fail_pin,
	input  wire logic        optical_signal_detect_pin,
	input  wire logic        power_down_pin_n,
	input  wire logic        copperLinkUp,
	input  wire logic        copperFullDuplex,
	input  wire logic        copper100M,
	input  wire logic        portCtlAutoneg,
	// Outputs
	output logic      [7:0]  statusLow,
	output logic      [7:0]  statusHigh,
	output logic      [23:0] vendor_ident_bits,
	output logic             irq
);
	logic        notify_reg;
	logic        diag_reg;
	logic        linkDown_reg;
	logic        ifCount_reg;
	logic [7:0]  vendor_reg [3];
	logic [4:0]  irqStatus_reg;
	logic [4:0]  irqMask_reg;
	logic [4:0]  watch;
	logic [4:0]  watch_reg;
	logic [4:0]  irqEvent;
	logic [9:0]  idx;
	logic        wrEn;
	logic        rdEn;
	logic        hit;
	logic        wrLow;
	logic [7:0]  rdByte;
	logic        roleBit;
	logic        autonegBit;
	logic        duplexBit;
	logic        speedBit;
	logic [7:0]  statusLow_next;
	logic [7:0]  statusHigh_next;
	logic        wrStatusLow;
	logic        wrStatusHigh;
	logic        wrIrqStatus;
	logic        wrIrqMask;
	logic [2:0]  wrVendor;
	logic        primed_reg;

	assign idx    = paddr[11:2];
	assign wrEn   = psel && penable && pwrite;
	assign rdEn   = psel && !penable && !pwrite;
	// Every register answers at once, so no wait states
	assign pready = 1'b1;
	assign wrLow  = wrEn && pstrb[0];

	// Terminal side reflects pins and port status; center side reads 0
	assign roleBit    = terminalMode;
	assign autonegBit = terminalMode && portCtlAutoneg;
	assign duplexBit  = terminalMode && copperLinkUp && copperFullDuplex;
	assign speedBit   = terminalMode && copperLinkUp && copper100M;

	// Live status view; the read path and the output flops both use it
	always_comb
	begin
		statusLow_next                = 8'h00;
		statusLow_next[BIT_ROLE]      = roleBit;
		statusLow_next[BIT_LOOPBACK]  = loopbackActive;
		statusLow_next[BIT_NOTIFY]    = notify_reg;
		statusLow_next[BIT_DIAG]      = diag_reg;
		statusLow_next[BIT_LINKDOWN]  = linkDown_reg;
		statusLow_next[BIT_OPTDETECT] = optical_signal_detect_pin;
		statusLow_next[BIT_PWRDOWN]   = !power_down_pin_n;
		statusHigh_next               = 8'h00;
		statusHigh_next[BIT_IFCOUNT]  = ifCount_reg;
		statusHigh_next[BIT_ANEG]     = autonegBit;
		statusHigh_next[BIT_DUPLEX]   = duplexBit;
		statusHigh_next[BIT_SPEED]    = speedBit;
	end

	// Status ports come from flops, one cycle behind the live view
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			statusLow  <= 8'(RST_LINKDOWN) << BIT_LINKDOWN;
			statusHigh <= 8'(RST_IFCOUNT) << BIT_IFCOUNT;
		end
		else
		begin
			statusLow  <= statusLow_next;
			statusHigh <= statusHigh_next;
		end
	end

	// Read decode; anything outside the map reads zero and is refused
	always_comb
	begin
		hit = 1'b1;
		if (idx[9:8] != 2'b00)
		begin
			hit    = 1'b0;
			rdByte = 8'h00;
		end
		else if (idx[7:0] == IDX_STATUS_LOW)
			rdByte = statusLow_next;
		else if (idx[7:0] == IDX_STATUS_HIGH)
			rdByte = statusHigh_next;
		else if (idx[7:0] == IDX_VENDOR0)
			rdByte = vendor_reg[0];
		else if (idx[7:0] == IDX_VENDOR1)
			rdByte = vendor_reg[1];
		else if (idx[7:0] == IDX_VENDOR2)
			rdByte = vendor_reg[2];
		else if (idx[7:0] == IDX_IRQ_STATUS)
			rdByte = {3'b000, irqStatus_reg};
		else if (idx[7:0] == IDX_IRQ_MASK)
			rdByte = {3'b000, irqMask_reg};
		else
		begin
			hit    = 1'b0;
			rdByte = 8'h00;
		end
	end

	// Unmapped access answers with an error, no state changes
	assign pslverr = psel && penable && !hit;

	// One strobe per mapped register; refused accesses raise none
	always_comb
	begin
		wrStatusLow  = 1'b0;
		wrStatusHigh = 1'b0;
		wrIrqStatus  = 1'b0;
		wrIrqMask    = 1'b0;
		if (wrLow && hit)
		begin
			if (idx[7:0] == IDX_STATUS_LOW)
				wrStatusLow = 1'b1;
			else if (idx[7:0] == IDX_STATUS_HIGH)
				wrStatusHigh = 1'b1;
			else if (idx[7:0] == IDX_IRQ_STATUS)
				wrIrqStatus = 1'b1;
			else if (idx[7:0] == IDX_IRQ_MASK)
				wrIrqMask = 1'b1;
		end
	end

	// Read data captured in setup so it stands through the access phase
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			prdata <= 32'h0000_0000;
		else if (rdEn)
			prdata <= {24'h00_0000, rdByte};
	end

	// Notify select: strap in terminal mode, software in center mode
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			notify_reg <= RST_NOTIFY;
		else if (terminalMode)
			notify_reg <= notifyStrap;
		else if (wrStatusLow)
			notify_reg <= pwdata[BIT_NOTIFY];
	end

	// Diag result tracks the fail pin in terminal mode
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			diag_reg <= 1'b0;
		else if (terminalMode)
			diag_reg <= diagnostic_fail_pin;
		else if (wrStatusLow)
			diag_reg <= pwdata[BIT_DIAG];
	end

	// Link-down is read only on the terminal side
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			linkDown_reg <= RST_LINKDOWN;
		else if (terminalMode)
			linkDown_reg <= !copperLinkUp;
		else if (wrStatusLow)
			linkDown_reg <= pwdata[BIT_LINKDOWN];
	end

	// Only the interface-count bit of status high is writable
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			ifCount_reg <= RST_IFCOUNT;
		else if (wrStatusHigh)
			ifCount_reg <= pwdata[BIT_IFCOUNT];
	end

	// Vendor identity bytes, plain storage
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : gVendor
			assign wrVendor[g] = wrLow && hit && idx[7:0] == IDX_VENDOR0 + 8'(g);
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
					vendor_reg[g] <= RST_VENDOR;
				else if (wrVendor[g])
					vendor_reg[g] <= pwdata[7:0];
			end
		end
	endgenerate

	assign vendor_ident_bits = {vendor_reg[2], vendor_reg[1], vendor_reg[0]};

	// Change events on watched status
	always_comb
	begin
		watch               = 5'h00;
		watch[IRQ_LINK]     = linkDown_reg;
		watch[IRQ_OPT]      = optical_signal_detect_pin;
		watch[IRQ_DIAG]     = diag_reg;
		watch[IRQ_PWR]      = !power_down_pin_n;
		watch[IRQ_LOOPBACK] = loopbackActive;
	end

	// Snapshot of the watched state for change detection
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			watch_reg <= 5'h00;
		else
			watch_reg <= watch;
	end

	// First edge after reset only loads the snapshot, so no false event
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			primed_reg <= 1'b0;
		else
			primed_reg <= 1'b1;
	end

	assign irqEvent = primed_reg ? (watch ^ watch_reg) : 5'h00;

	// Set wins over write-one-to-clear in the same cycle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irqStatus_reg <= 5'h00;
		else if (wrIrqStatus)
			irqStatus_reg <= (irqStatus_reg & ~pwdata[4:0]) | irqEvent;
		else
			irqStatus_reg <= irqStatus_reg | irqEvent;
	end

	// Mask shares the layout of the status bits
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irqMask_reg <= RST_IRQ_MASK;
		else if (wrIrqMask)
			irqMask_reg <= pwdata[4:0];
	end

	// Level output: high while any unmasked status bit is set
	assign irq = |(irqStatus_reg & irqMask_reg);
endmodule // oam_local_status_regs

// *** verif/oam_local_status_regs_chk.sv ***
`timescale 1ns/1ns
module oam_local_status_regs_chk
	import oam_pkg::*;
(
	// Clock, reset and bus
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	// Pins
	input wire logic        terminalMode,
	input wire logic        loopbackActive,
	input wire logic        notifyStrap,
	input wire logic        diagnostic_fail_pin,
	input wire logic        optical_signal_detect_pin,
	input wire logic        power_down_pin_n,
	input wire logic        copperLinkUp,
	input wire logic        copperFullDuplex,
	input wire logic        copper100M,
	input wire logic        portCtlAutoneg,
	// Status view
	input wire logic [7:0]  statusLow,
	input wire logic [7:0]  statusHigh
);
	logic [9:0] pinQ;
	logic [9:0] pinQ2;
	logic [1:0] up;
	wire  [9:0] pins = {terminalMode, loopbackActive, notifyStrap, diagnostic_fail_pin,
		optical_signal_detect_pin, power_down_pin_n, copperLinkUp, copperFullDuplex,
		copper100M, portCtlAutoneg};
	// Pins steady two cycles: status flops lag the pin-tracking flops by one
	wire        calm  = up[1] && pins == pinQ && pinQ == pinQ2;
	wire        tm    = calm && terminalMode;
	wire        wrLow = psel && penable && pwrite && paddr == {2'b00, IDX_STATUS_LOW, 2'b00};

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			{up, pinQ2, pinQ} <= 22'h0;
		else
			{up, pinQ2, pinQ} <= {up[0], 1'b1, pinQ, pins};
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	chk_role_bit: assert property (calm |-> statusLow[BIT_ROLE] == terminalMode)
		else $error("role bit wrong");
	chk_loop_flag: assert property (calm |-> statusLow[BIT_LOOPBACK] == loopbackActive)
		else $error("loopback bit wrong");
	chk_notify_strap: assert property (tm |-> statusLow[BIT_NOTIFY] == notifyStrap)
		else $error("notify bit wrong");
	chk_diag_pin: assert property (tm |-> statusLow[BIT_DIAG] == diagnostic_fail_pin)
		else $error("diag bit wrong");
	chk_link_down: assert property (tm |-> statusLow[BIT_LINKDOWN] == !copperLinkUp)
		else $error("link down bit wrong");
	chk_optical_pin: assert property (calm |-> statusLow[1] == optical_signal_detect_pin)
		else $error("optical bit wrong");
	chk_power_inv: assert property (calm |-> statusLow[0] == !power_down_pin_n)
		else $error("power bit wrong");
	chk_copper_mode: assert property (calm |-> statusHigh[2:0] == (terminalMode ?
		{portCtlAutoneg, {copperFullDuplex, copper100M} & {2{copperLinkUp}}} : 3'h0))
		else $error("copper bits wrong");
	chk_ro_ignored: assert property (tm && wrLow ##1 calm ##1 calm |-> $stable(statusLow))
		else $error("read-only write took effect");

	cover property (tm && wrLow);
	cover property (calm && !terminalMode && statusHigh[BIT_IFCOUNT]);
	cover property (tm && !copperLinkUp && copperFullDuplex);
endmodule // oam_local_status_regs_chk

bind oam_local_status_regs oam_local_status_regs_chk u_chk (.*);

// *** verif/tb.sv ***
`timescale 1ns/1ns
module tb
	import oam_pkg::*;
;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hf;
	logic [31:0] prdata;
	logic        pready, pslverr, irq, err;
	logic        terminalMode, loopbackActive, notifyStrap, diagnostic_fail_pin;
	logic        optical_signal_detect_pin, power_down_pin_n, copperLinkUp;
	logic        copperFullDuplex, copper100M, portCtlAutoneg;
	logic [7:0]  statusLow, statusHigh;
	logic [23:0] vendor_ident_bits;
	int          errors = 0;
	int          num_checks = 0;
	int          cyc = 0;

	oam_local_status_regs u_oam_local_status_regs (.*);

	always #5 clk = ~clk;

	// Whole run needs under a hundred cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			errors++;
			print_verdict();
		end
	end

	task print_verdict();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task ck(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	// Order: mode, loop, strap, fail, optical, pwr_n, link, full, 100M, aneg
	task setp(input logic [9:0] v);
		{terminalMode, loopbackActive, notifyStrap, diagnostic_fail_pin,
			optical_signal_detect_pin, power_down_pin_n, copperLinkUp,
			copperFullDuplex, copper100M, portCtlAutoneg} <= v;
	endtask

	task xfer(input logic [7:0] i, input logic w, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [7:0] i, input logic [7:0] e);
		xfer(i, 1'b0, 8'h0);
		ck(prdata, {24'h0, e});
	endtask

	initial
	begin
		setp(10'b1111100111);
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		rd(IDX_IRQ_MASK, 8'h00);
		rd(IDX_STATUS_LOW, 8'h7f);
		rd(IDX_STATUS_HIGH, 8'h04);
		xfer(IDX_STATUS_LOW, 1'b1, 8'h00);
		rd(IDX_STATUS_LOW, 8'h7f);
		$display("test 1 done");
		setp(10'b1000011110);
		rd(IDX_STATUS_LOW, 8'h40);
		rd(IDX_STATUS_HIGH, 8'h03);
		$display("test 2 done");
		rd(IDX_IRQ_STATUS, 8'h1f);
		ck(32'(irq), 32'h0);
		xfer(IDX_IRQ_MASK, 1'b1, 8'h1f);
		@(posedge clk);
		ck(32'(irq), 32'h1);
		xfer(IDX_IRQ_STATUS, 1'b1, 8'h1f);
		@(posedge clk);
		ck(32'(irq), 32'h0);
		rd(IDX_IRQ_STATUS, 8'h00);
		xfer(IDX_ROLE_CTRL, 1'b1, 8'hff);
		ck(32'(err), 32'h1);
		$display("test 3 done");
		setp(10'b0000011110);
		xfer(IDX_STATUS_LOW, 1'b1, 8'h5f);
		rd(IDX_STATUS_LOW, 8'h1c);
		xfer(IDX_STATUS_HIGH, 1'b1, 8'h0f);
		rd(IDX_STATUS_HIGH, 8'h08);
		$display("test 4 done");
		for (int k = 0; k < 3; k++)
			xfer(8'(IDX_VENDOR0 + k), 1'b1, 8'(8'ha5 + k));
		rd(IDX_VENDOR1, 8'ha6);
		ck({8'h0, vendor_ident_bits}, 32'h00a7a6a5);
		$display("test 5 done");
		print_verdict();
	end
endmodule // tb
